// ---- tb/pse_sink.sv ----
// Pattern sink model standing in for the circuit under test on the probe side.
`default_nettype none
module pse_sink
    import pse_pkg::*;
(
    input  wire logic       hclk,      // Pattern clock.
    input  wire logic       hresetn,   // Synchronous reset, active low.
    input  wire logic       pat_valid, // Vector offered by the engine.
    input  wire logic [1:0] mode,      // 0 ready, 1 random stalls, 2 hold off.
    output logic            pat_ready  // Sink accepts.
);
    timeunit 1ns;
    timeprecision 1ns;
    int seed;

    // Ready changes only just after an edge; random stalls test the back-pressure path.
    initial
    begin
        seed = 15558;
        pat_ready = 1'b0;
        forever
        begin
            @(posedge hclk);
            if (!hresetn || mode == 2'd2)
                pat_ready <= 1'b0;
            else if (mode == 2'd1)
                pat_ready <= !pat_valid || ($random(seed) % 3 != 0);
            else
                pat_ready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the pattern sequence engine.
`default_nettype none
module tb
    import pse_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        hclk, hresetn, hsel, hwrite, evt_bp, evt_out;
    logic        hreadyout, hresp, pat_valid, pat_ready;
    logic [11:0] haddr;
    logic [1:0]  htrans, mode;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, pat_data, rd;
    logic [7:0]  evt_probe, sz [3];
    logic [31:0] vec [48];
    logic [31:0] got [$];
    logic [31:0] exp_q [$];
    int          num_errors, n_tests, seed, r0, r1, i, gaps;

    pse_engine pse_engine_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .evt_bp(evt_bp),
        .evt_probe(evt_probe), .evt_out(evt_out), .pat_valid(pat_valid),
        .pat_ready(pat_ready), .pat_data(pat_data));
    pse_sink pse_sink_i (.hclk(hclk), .hresetn(hresetn), .pat_valid(pat_valid),
        .mode(mode), .pat_ready(pat_ready));

    // Free-running 50 MHz clock.
    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // Every accepted vector is logged for comparison against the expected stream.
    always @(posedge hclk)
        if (hresetn === 1'b1 && pat_valid === 1'b1 && pat_ready === 1'b1)
            got.push_back(pat_data);

    task automatic close_out();
        $display("errors %0d, comparisons %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Waits for hready under a bound; a hang ends the run.
    task automatic wait_ready();
        int k;
        k = 0;
        do
        begin
            @(posedge hclk);
            k++;
        end
        while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50)
        begin
            num_errors++;
            close_out();
        end
    endtask

    // One single AHB-Lite word transfer; read data lands in rd.
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wait_got(input int n);
        int k;
        for (k = 0; k < 3000 && got.size() < n; k++)
            @(posedge hclk);
        if (got.size() < n)
        begin
            num_errors++;
            close_out();
        end
    endtask

    task automatic push_blk(input int b);
        for (int j = 0; j < sz[b]; j++)
            exp_q.push_back(vec[16 * b + j]);
    endtask

    task automatic line_w(input int n, input pse_line_t l);
        ahb(1'b1, 12'h200 + 12'(4 * n), 32'(l));
    endtask

    // Main sequence: long flow run, step mode, then an endless line.
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 12'h000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        evt_bp = 1'b0;
        evt_probe = 8'h00;
        mode = 2'd2;
        num_errors = 0;
        n_tests = 0;
        seed = 15558;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, PSE_NLINE_OFS, 32'h0000_0000);
        check("nlines reset", rd, 32'(PSE_NLINE_RST));
        ahb(1'b0, 12'hFF0, 32'h0000_0000);
        check("unmapped read", rd, 32'h0000_0000);
        check("okay response", 32'(hresp), 32'h0000_0000);
        for (i = 0; i < 48; i++)
        begin
            vec[i] = $random(seed);
            ahb(1'b1, 12'h400 + 12'(4 * i), vec[i]);
        end
        sz[0] = 8'(3 + ($random(seed) & 1));
        sz[1] = 8'(1 + ($random(seed) & 3));
        sz[2] = 8'(1 + ($random(seed) & 3));
        r0 = 6 + ($random(seed) & 1);
        r1 = 1 + ($random(seed) & 1);
        for (i = 0; i < 3; i++)
            ahb(1'b1, 12'h300 + 12'(4 * i), 32'(pse_blk_t'{size: sz[i], start: 8'(16 * i)}));
        ahb(1'b1, 12'h380, 32'(pse_sub_t'{cnt: 3'd2, blk: {4'd0, 4'd0, 4'd2, 4'd1}}));
        // Event 0: backplane AND probe line 1, OR probe line 5 alone.
        for (i = 0; i < 4; i++)
            ahb(1'b1, 12'h100 + 12'(4 * i), i == 0 ? 32'h0000_0005 : i == 1 ? 32'h0000_0040 : 0);
        line_w(0, '{lvl: 1'b1, rpt: 8'(r0), default: '0});
        line_w(1, '{wt: 1'b1, sub: 1'b1, rpt: 8'(r1), default: '0});
        line_w(2, '{tgt: 4'd2, jmp: 1'b1, jto: 4'd4, default: '0});
        line_w(3, '{lvl: 1'b1, default: '0});
        line_w(4, '{tgt: 4'd1, lvl: 1'b1, default: '0});
        ahb(1'b1, PSE_NLINE_OFS, 32'h0000_0005);
        for (i = 0; i < r0; i++)
            push_blk(0);
        for (i = 0; i < r1; i++)
        begin
            push_blk(1);
            push_blk(2);
        end
        push_blk(2);
        push_blk(1);
        // Sink held off long enough for the FIFO to fill and stall the engine.
        ahb(1'b1, PSE_CTRL_OFS, 32'h0000_0001);
        repeat (40) @(posedge hclk);
        check("stalled count", 32'(got.size()), 32'h0000_0000);
        check("held valid", 32'(pat_valid), 32'h0000_0001);
        mode <= 2'd1;
        wait_got(sz[0] * r0);
        repeat (30) @(posedge hclk);
        check("count in wait", 32'(got.size()), 32'(sz[0] * r0));
        check("level in wait", 32'(evt_out), 32'h0000_0000);
        evt_bp <= 1'b1;
        repeat (20) @(posedge hclk);
        check("count half row", 32'(got.size()), 32'(sz[0] * r0));
        evt_probe <= 8'h02;
        wait_got(exp_q.size());
        repeat (30) @(posedge hclk);
        check("total count", 32'(got.size()), 32'(exp_q.size()));
        for (i = 0; i < exp_q.size(); i++)
            check("stream vector", got[i], exp_q[i]);
        ahb(1'b0, PSE_STAT_OFS, 32'h0000_0000);
        check("done state", 32'(rd[1:0]), 32'h0000_0002);
        check("final level", 32'(rd[8]), 32'h0000_0001);
        // Step mode: nothing moves until a step write, then one vector each.
        mode <= 2'd0;
        ahb(1'b1, PSE_NLINE_OFS, 32'h0000_0001);
        got.delete();
        ahb(1'b1, PSE_CTRL_OFS, 32'h0000_0003);
        ahb(1'b0, PSE_CTRL_OFS, 32'h0000_0000);
        check("step mode bit", rd, 32'h0000_0002);
        repeat (10) @(posedge hclk);
        check("step idle", 32'(got.size()), 32'h0000_0000);
        for (i = 0; i < sz[0]; i++)
        begin
            ahb(1'b1, PSE_STEP_OFS, 32'h0000_0001);
            repeat (6) @(posedge hclk);
            check("step count", 32'(got.size()), 32'(i + 1));
            check("step vector", got[i], vec[i]);
        end
        // Endless line: block 1 repeats gap-free and control never leaves.
        line_w(0, '{tgt: 4'd1, inf: 1'b1, default: '0});
        got.delete();
        ahb(1'b1, PSE_CTRL_OFS, 32'h0000_0001);
        wait_got(4);
        gaps = 0;
        repeat (40)
        begin
            @(posedge hclk);
            if (pat_valid !== 1'b1)
                gaps++;
        end
        check("gap cycles", 32'(gaps), 32'h0000_0000);
        for (i = 0; i < 40; i++)
            check("endless vector", got[i], vec[16 + i % sz[1]]);
        ahb(1'b0, PSE_STAT_OFS, 32'h0000_0000);
        check("run state", 32'(rd[1:0]), 32'h0000_0001);
        ahb(1'b1, PSE_CTRL_OFS, 32'h0000_0004);
        ahb(1'b0, PSE_STAT_OFS, 32'h0000_0000);
        check("aborted state", 32'(rd[1:0]), 32'h0000_0000);
        close_out();
    end
endmodule
`default_nettype wire

// ---- verilog/pse_engine.sv ----
// Pattern sequence engine with its AHB-Lite register slave and output FIFO.
//
// What this block does
// - Emit selected block repeat-count times per line.
// - Hold line output until wait event true.
// - Finished line continues at its jump target.
// - Subsequence emits its blocks, then returns.
// - Drive line's level onto event output.
// - Infinite repeat line never passes control on.
// - Finite line without jump goes to next.
// - Stop and emit nothing after last line.
// - Event inputs: backplane plus two per probe.
// - Event is OR of rows of ANDed inputs.
// - Vectors held as numbered blocks with sizes.
// - Advance per clock, or per step command.
//
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`default_nettype none

// Synchronous FIFO; output data read straight from the array.
module pse_fifo
    import pse_pkg::*;
#(
    parameter int W = 32,
    parameter int D = 16
) (
    input  wire logic         hclk,      // Clock.
    input  wire logic         hresetn,   // Asynchronous reset, active low.
    input  wire logic         clr,       // Discard contents.
    input  wire logic         in_valid,  // Write request.
    output logic              in_ready,  // Space available.
    input  wire logic [W-1:0] in_data,   // Write data.
    output logic              out_valid, // Data available.
    input  wire logic         out_ready, // Read request.
    output logic [W-1:0]      out_data   // Oldest word.
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          wr;
    logic          rd;

    // Full and empty come from the occupancy count.
    assign in_ready  = (cnt != (AW+1)'(D));
    assign out_valid = (cnt != '0);
    assign out_data  = mem[rp];
    assign wr        = in_valid && in_ready;
    assign rd        = out_valid && out_ready;

    // Pointers and count.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
        end
        else if (clr)
        begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
        end
        else
        begin
            if (wr)
                wp <= (wp == AW'(D - 1)) ? '0 : wp + 1'b1;
            if (rd)
                rp <= (rp == AW'(D - 1)) ? '0 : rp + 1'b1;
            cnt <= cnt + (AW+1)'(wr) - (AW+1)'(rd);
        end
    end

    // Storage needs no reset.
    always_ff @(posedge hclk)
    begin
        if (wr)
            mem[wp] <= in_data;
    end
endmodule

module pse_engine
    import pse_pkg::*;
#(
    parameter int VW    = 32,
    parameter int FDEPTH = 16
) (
    input  wire logic            hclk,      // Pattern clock, 50 MHz.
    input  wire logic            hresetn,   // Asynchronous reset, active low.
    input  wire logic            hsel,      // Slave select.
    input  wire logic [11:0]     haddr,     // Byte address.
    input  wire logic [1:0]      htrans,    // Transfer type.
    input  wire logic            hwrite,    // Write when high.
    input  wire logic [2:0]      hsize,     // Transfer size, word only.
    input  wire logic [31:0]     hwdata,    // Write data.
    input  wire logic            hready,    // Bus ready.
    output logic                 hreadyout, // Ready from the first edge after reset.
    output logic                 hresp,     // Always OKAY.
    output logic [31:0]          hrdata,    // Read data.
    input  wire logic            evt_bp,    // Backplane event input.
    input  wire logic [7:0]      evt_probe, // Two event lines per probe.
    output logic                 evt_out,   // Event output line level.
    output logic                 pat_valid, // Pattern vector valid.
    input  wire logic            pat_ready, // Pattern sink accepts.
    output logic [VW-1:0]        pat_data   // Pattern vector.
);
    // All state of the engine in one record.
    typedef struct packed {
        pse_state_t  st;
        logic [3:0]  li;
        logic [7:0]  rep;
        logic [1:0]  sp;
        logic [7:0]  vi;
        logic        armed;
        logic        evo;
        logic        stepm;
        logic        steppend;
        logic [4:0]  nlines;
        logic        wpend;
        logic [11:0] waddr;
        logic [31:0] rdata;
        logic        rdy;
        logic        pv;
        logic [VW-1:0] pd;
    } pse_reg_t;

    pse_reg_t  r;
    pse_reg_t  next_r;

    // Program tables written by software.
    logic [PSE_NEVIN-1:0] evt_def [PSE_NEVT][PSE_NROWS];
    pse_line_t            seq_mem [PSE_NLINES];
    pse_blk_t             blk_tbl [16];
    pse_sub_t             sub_tbl [16];
    logic [VW-1:0]        vec_mem [PSE_VDEPTH];

    pse_line_t            ln;
    pse_blk_t             bk;
    logic [3:0]           bno;
    logic [PSE_NEVIN-1:0] evin;
    logic                 cond;
    logic                 go;
    logic                 push;
    logic                 f_ready;
    logic                 f_valid;
    logic                 f_take;
    logic [VW-1:0]        f_data;
    logic                 aphase;
    logic                 clr;
    logic                 last_v;
    logic                 last_b;
    logic                 last_r;

    // True when any row has every selected input true; empty rows never fire.
    function automatic logic evt_true(input logic [1:0] e,
                                      input logic [PSE_NEVIN-1:0] in);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < PSE_NROWS; i++)
            if (evt_def[e][i] != '0 && (evt_def[e][i] & ~in) == '0)
                hit = 1'b1;
        return hit;
    endfunction

    // Decode of the current line, its block and the wait condition.
    assign evin = {evt_probe, evt_bp};
    assign ln   = seq_mem[r.li];
    assign bno  = ln.sub ? sub_tbl[ln.tgt].blk[r.sp] : ln.tgt;
    assign bk   = blk_tbl[bno];
    assign cond = evt_true(ln.evs, evin);
    assign go   = r.armed || !ln.wt || cond;
    assign last_v = (8'(r.vi + 8'h01) >= bk.size);
    assign last_b = !ln.sub || (3'(r.sp) + 3'h1 >= sub_tbl[ln.tgt].cnt);
    assign last_r = !ln.inf && (8'(r.rep + 8'h01) >= ((ln.rpt == 8'h00) ? 8'h01 : ln.rpt));
    // Step mode spends one pending step per vector; normal mode needs no step, only run state, go and FIFO space.
    assign push = (r.st == PSE_RUN) && go && f_ready
                  && (!r.stepm || r.steppend);
    assign aphase = hsel && htrans[1] && hready;
    assign f_take = !r.pv || pat_ready;
    assign clr    = r.wpend && (r.waddr == PSE_CTRL_OFS)
                    && hwdata[PSE_CTRL_START];

    pse_fifo #(.W(VW), .D(FDEPTH)) u_fifo (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .clr       (clr),
        .in_valid  (push),
        .in_ready  (f_ready),
        .in_data   (vec_mem[8'(bk.start + r.vi)]),
        .out_valid (f_valid),
        .out_ready (f_take),
        .out_data  (f_data)
    );

    // Next-state logic for bus, engine and output register.
    always_comb
    begin
        next_r = r;
        next_r.rdy = 1'b1; // Ready rises on the first edge after reset.
        // Bus address phase: latch writes, prepare read data.
        next_r.wpend = aphase && hwrite;
        if (aphase)
            next_r.waddr = haddr;
        if (aphase && !hwrite)
        begin
            case (haddr)
                PSE_CTRL_OFS:  next_r.rdata = {30'h0, r.stepm, 1'b0};
                PSE_STAT_OFS:  next_r.rdata = {23'h0, r.evo, r.li, 2'b00, r.st};
                PSE_NLINE_OFS: next_r.rdata = {27'h0, r.nlines};
                default:       next_r.rdata = 32'h0000_0000;
            endcase
        end
        // Engine advance, one vector per accepted push.
        if (push)
        begin
            next_r.armed = 1'b1;
            next_r.vi    = last_v ? 8'h00 : 8'(r.vi + 8'h01);
            if (last_v)
            begin
                next_r.sp = last_b ? 2'b00 : 2'(r.sp + 2'b01);
                if (last_b)
                begin
                    next_r.rep = 8'(r.rep + 8'h01);
                    if (ln.inf)
                        next_r.rep = 8'h00;
                    if (last_r)
                    begin
                        next_r.rep   = 8'h00;
                        next_r.armed = 1'b0;
                        if (ln.jmp)
                            next_r.li = ln.jto;
                        else if (5'(r.li) + 5'h01 >= r.nlines)
                            next_r.st = PSE_DONE;
                        else
                            next_r.li = 4'(r.li + 4'h1);
                    end
                end
            end
        end
        if (r.st == PSE_RUN)
            next_r.evo = ln.lvl;
        // A new step request wins over the one being consumed.
        if (push && r.stepm)
            next_r.steppend = 1'b0;
        // Register writes in the data phase.
        if (r.wpend && r.waddr == PSE_STEP_OFS)
            next_r.steppend = 1'b1;
        if (r.wpend && r.waddr == PSE_NLINE_OFS)
            next_r.nlines = hwdata[4:0];
        if (r.wpend && r.waddr == PSE_CTRL_OFS)
        begin
            next_r.stepm = hwdata[PSE_CTRL_STEPM];
            if (hwdata[PSE_CTRL_ABORT])
                next_r.st = PSE_IDLE;
            if (hwdata[PSE_CTRL_START])
            begin
                next_r.st    = (r.nlines == 5'h00) ? PSE_DONE : PSE_RUN;
                next_r.li    = 4'h0;
                next_r.rep   = 8'h00;
                next_r.sp    = 2'b00;
                next_r.vi    = 8'h00;
                next_r.armed = 1'b0;
                next_r.steppend = 1'b0;
            end
        end
        // Output skid register keeps the pattern port straight from a flop.
        if (f_take)
        begin
            next_r.pv = f_valid;
            next_r.pd = f_data;
        end
        if (clr)
            next_r.pv = 1'b0;
    end

    // State register.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r        <= '0;
            r.st     <= PSE_IDLE;
            r.nlines <= PSE_NLINE_RST;
            r.rdata  <= PSE_HRDATA_RST;
        end
        else
            r <= next_r;
    end

    // Table writes; only whole words are supported on this bus.
    always_ff @(posedge hclk)
    begin
        if (r.wpend)
        begin
            if (r.waddr[11:10] == PSE_RGN_VEC)
                vec_mem[r.waddr[9:2]] <= hwdata[VW-1:0];
            else if (r.waddr[11:8] == PSE_RGN_EVT)
                evt_def[r.waddr[5:4]][r.waddr[3:2]] <= hwdata[PSE_NEVIN-1:0];
            else if (r.waddr[11:8] == PSE_RGN_SEQ)
                seq_mem[r.waddr[5:2]] <= hwdata[$bits(pse_line_t)-1:0];
            else if (r.waddr[11:8] == PSE_RGN_TBL && !r.waddr[7])
                blk_tbl[r.waddr[5:2]] <= hwdata[$bits(pse_blk_t)-1:0];
            else if (r.waddr[11:8] == PSE_RGN_TBL)
                sub_tbl[r.waddr[5:2]] <= hwdata[$bits(pse_sub_t)-1:0];
        end
    end

    // Outputs straight from flops, hresp tied low; the slave never stalls and never errs.
    assign hreadyout = r.rdy;
    assign hresp     = 1'b0;
    assign hrdata    = r.rdata;
    assign evt_out   = r.evo;
    assign pat_valid = r.pv;
    assign pat_data  = r.pd;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Waiting line emits nothing while its event is false.
    wait_hold_a: assert property ((r.st == PSE_RUN) && ln.wt && !r.armed && !cond
                                 |-> !push)
        else $error("Vector pushed before wait event.");
    // Consecutive vectors of a block are ascending.
    vec_order_a: assert property (push && !(8'(r.vi + 8'h01) >= bk.size)
                                  |=> r.vi == $past(r.vi) + 8'h01)
        else $error("Vector index did not advance by one.");
    // After the last line the engine stops.
    done_stop_a: assert property (r.st == PSE_DONE |-> !push)
        else $error("Push after program end.");
    // Infinite line never leaves its line.
    inf_stay_a: assert property ((r.st == PSE_RUN) && ln.inf && !(r.wpend && r.waddr == PSE_CTRL_OFS)
                                 |=> $stable(r.li) && r.st == PSE_RUN)
        else $error("Infinite line passed control.");
    // Jump line lands on its target.
    jump_land_a: assert property (push && ln.jmp && last_v && last_b && last_r
                                  && !clr |=> r.li == $past(ln.jto))
        else $error("Jump did not reach target.");
    // Event output follows line level one cycle later.
    level_out_a: assert property ((r.st == PSE_RUN) && !clr
                                  |=> evt_out == $past(ln.lvl))
        else $error("Event output level wrong.");
    // Step mode needs a pending step for each vector.
    step_gate_a: assert property (push && r.stepm && !(r.wpend && r.waddr == PSE_STEP_OFS)
                                  |=> !r.steppend)
        else $error("Step mode advanced without command.");
    // Repeat counter stays below the finite repeat count.
    rep_bound_a: assert property ((r.st == PSE_RUN) && !ln.inf && ln.rpt != 8'h00
                                  |-> r.rep < ln.rpt)
        else $error("Repeat count overran.");
    // Without jump, a finished line moves to the next one.
    next_line_a: assert property (push && !ln.jmp && last_v && last_b && last_r
                                  && 5'(r.li) + 5'h01 < r.nlines && !clr
                                  |=> r.li == $past(r.li) + 4'h1)
        else $error("Line did not advance.");
    // Subsequence walks its block list.
    sub_walk_a: assert property (push && ln.sub && !clr
                                 && 8'(r.vi + 8'h01) >= bk.size
                                 && 3'(r.sp) + 3'h1 < sub_tbl[ln.tgt].cnt
                                 |=> r.sp == $past(r.sp) + 2'b01)
        else $error("Subsequence block order broken.");

    run_done_c: cover property (r.st == PSE_RUN ##[1:200] r.st == PSE_DONE);
    wait_rel_c: cover property (ln.wt && !cond && r.st == PSE_RUN ##1 cond);
    fifo_full_c: cover property (r.st == PSE_RUN && !f_ready);
    sub_call_c: cover property (push && ln.sub && r.sp == 2'b01);
endmodule
`default_nettype wire

// ---- verilog/pse_pkg.sv ----
// Package of constants and types for the pattern sequence engine.
`default_nettype none
package pse_pkg;
    // Register byte offsets and address regions.
    localparam logic [11:0] PSE_CTRL_OFS   = 12'h000;
    localparam logic [11:0] PSE_STEP_OFS   = 12'h004;
    localparam logic [11:0] PSE_STAT_OFS   = 12'h008;
    localparam logic [11:0] PSE_NLINE_OFS  = 12'h00C;
    localparam logic [3:0]  PSE_RGN_CTRL   = 4'h0;
    localparam logic [3:0]  PSE_RGN_EVT    = 4'h1;
    localparam logic [3:0]  PSE_RGN_SEQ    = 4'h2;
    localparam logic [3:0]  PSE_RGN_TBL    = 4'h3;
    localparam logic [1:0]  PSE_RGN_VEC    = 2'h1;
    // Control register bit positions.
    localparam int PSE_CTRL_START = 0;
    localparam int PSE_CTRL_STEPM = 1;
    localparam int PSE_CTRL_ABORT = 2;
    // Reset values.
    localparam logic [4:0]  PSE_NLINE_RST  = 5'h00;
    localparam logic [31:0] PSE_HRDATA_RST = 32'h0000_0000;
    // Sizes of the program tables.
    localparam int PSE_NLINES = 16;
    localparam int PSE_NEVT   = 4;
    localparam int PSE_NROWS  = 4;
    localparam int PSE_NPROBE = 4;
    localparam int PSE_NEVIN  = 1 + 2 * PSE_NPROBE;
    localparam int PSE_SUBLEN = 4;
    localparam int PSE_VDEPTH = 256;

    // Engine states.
    typedef enum logic [1:0] {
        PSE_IDLE = 2'b00,
        PSE_RUN  = 2'b01,
        PSE_DONE = 2'b10
    } pse_state_t;

    // One sequence line as stored in the program table.
    typedef struct packed {
        logic       lvl;
        logic [3:0] jto;
        logic       jmp;
        logic [1:0] evs;
        logic       wt;
        logic       inf;
        logic [7:0] rpt;
        logic       sub;
        logic [3:0] tgt;
    } pse_line_t;

    // One data block descriptor: first vector and size.
    typedef struct packed {
        logic [7:0] size;
        logic [7:0] start;
    } pse_blk_t;

    // One subsequence: count of blocks and their numbers in order.
    typedef struct packed {
        logic [2:0]       cnt;
        logic [3:0][3:0] blk;
    } pse_sub_t;
endpackage
`default_nettype wire
